// ==== design/irh_bit_select.sv ====
// One routing multiplexer: picks the source of one status bit.
// Assumes inputs already synchronous; the result is registered above.
`timescale 1ns/10ps
`include "irh_defs.svh"

module irh_bit_select
   import irh_pkg::*;
(
   input wire irh_code_t code_i,
   input wire logic [`IRH_NUM_PHYS-1:0] phys_i,
   input wire logic [2:0] hall_i,
   input wire logic [2:0] enc_i,
   output logic bit_o
);

   always_comb
   begin
      bit_o = irh_src_bit(code_i, phys_i, hall_i, enc_i); // [RULE2] [RULE13]
   end

endmodule // irh_bit_select

// ==== design/irh_defs.svh ====
// Constants of the input routing and home capture block.
// Assumes inclusion by the package and by every design file.
`ifndef IRH_DEFS_SVH
`define IRH_DEFS_SVH

`define IRH_NUM_SEL 36
`define IRH_NUM_PHYS 16
`define IRH_ADR_W 8
`define IRH_HI_W 4

// Byte addresses of the register map
`define IRH_A_ROUTE_ENT 8'h00
`define IRH_A_ROUTE_EN 8'h04
`define IRH_A_POLARITY 8'h08
`define IRH_A_STATUS_LO 8'h0c
`define IRH_A_STATUS_HI 8'h10
`define IRH_A_CAP_ENT 8'h14
`define IRH_A_CAP_CTRL 8'h18
`define IRH_A_CAP_EVT 8'h1c
`define IRH_A_CAP_USER 8'h20
`define IRH_A_CAP_RAW 8'h24
`define IRH_A_IRQ_STAT 8'h28
`define IRH_A_IRQ_MASK 8'h2c
`define IRH_A_SEL_BASE 8'h40
`define IRH_A_SEL_LAST 8'hcc

// Reset and constant values
`define IRH_ROUTE_ENTRIES 8'h24
`define IRH_CAP_ENTRIES 8'h04
`define IRH_SEL_RESET 8'h00
`define IRH_WORD_RESET 32'h0000_0000

// Source code fields
`define IRH_CODE_INV 7
`define IRH_CODE_ZERO 7'h00
`define IRH_CODE_PHYS_LO 7'h01
`define IRH_CODE_PHYS_HI 7'h10
`define IRH_CODE_HALL_U 7'h41
`define IRH_CODE_HALL_W 7'h43
`define IRH_CODE_ENC_A 7'h44
`define IRH_CODE_ENC_I 7'h46

// Capture control values
`define IRH_CAP_OFF 2'h0
`define IRH_CAP_RISE 2'h1
`define IRH_CAP_FALL 2'h2
`define IRH_CAP_BOTH 2'h3
`define IRH_CAP_MAX 32'h0000_0003

// Status word bit that serves as home switch
`define IRH_HOME_BIT 2

// Interrupt status layout
`define IRH_IRQ_W 2
`define IRH_IRQ_CAPTURE 0
`define IRH_IRQ_CHANGE 1

`endif

// ==== design/irh_home_capture.sv ====
// Home switch capture: edge detect, position latch and capture counter.
// Assumes the home level is synchronous to clk_i; writes come merged.
`timescale 1ns/10ps
`include "irh_defs.svh"

module irh_home_capture
   import irh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic home_i,
   input wire logic [1:0] mode_i,
   input wire logic clear_i,
   input wire logic cnt_we_i,
   input wire logic user_we_i,
   input wire logic raw_we_i,
   input wire irh_word_t wdata_i,
   input wire irh_word_t user_pos_i,
   input wire irh_word_t raw_pos_i,
   output irh_word_t count_o,
   output irh_word_t user_o,
   output irh_word_t raw_o,
   output logic capture_o
);

   logic sync1;
   logic sync2;
   logic prev;
   logic rise;
   logic fall;
   irh_word_t next_count;
   irh_word_t next_user;
   irh_word_t next_raw;

   always_comb
   begin
      rise = sync2 & ~prev; // [RULE14]
      fall = ~sync2 & prev; // [RULE14]
      case (mode_i) // [RULE7]
         `IRH_CAP_RISE: capture_o = rise;
         `IRH_CAP_FALL: capture_o = fall;
         `IRH_CAP_BOTH: capture_o = rise | fall;
         default: capture_o = 1'b0;
      endcase
      next_count = count_o;
      next_user = user_o;
      next_raw = raw_o;
      if (clear_i)
      begin
         next_count = `IRH_WORD_RESET; // [RULE8]
      end
      else if (cnt_we_i)
      begin
         next_count = wdata_i;
      end
      if (user_we_i)
      begin
         next_user = wdata_i;
      end
      if (raw_we_i)
      begin
         next_raw = wdata_i;
      end
      // Capture beats a same-cycle position write and adds one to a written or cleared count, so no edge is lost
      if (capture_o)
      begin
         next_count = next_count + 32'h1; // [RULE8]
         next_user = user_pos_i; // [RULE6] [RULE9]
         next_raw = raw_pos_i; // [RULE10]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
         count_o <= `IRH_WORD_RESET;
         user_o <= `IRH_WORD_RESET;
         raw_o <= `IRH_WORD_RESET;
      end
      else
      begin
         sync1 <= home_i; // [RULE14]
         sync2 <= sync1;
         prev <= sync2;
         count_o <= next_count;
         user_o <= next_user;
         raw_o <= next_raw;
      end
   end

endmodule // irh_home_capture

// ==== design/irh_pkg.sv ====
// Types and shared decode functions of the routing block.
// Assumes irh_defs.svh on the include path.
`include "irh_defs.svh"

package irh_pkg;

   typedef logic [7:0] irh_code_t;
   typedef logic [31:0] irh_word_t;
   typedef logic [`IRH_ADR_W-1:0] irh_adr_t;

   // Value of one routed bit for a source code
   function automatic logic irh_src_bit(
      input irh_code_t code,
      input logic [`IRH_NUM_PHYS-1:0] phys,
      input logic [2:0] hall,
      input logic [2:0] enc);
      logic [6:0] base;
      logic [6:0] k;
      logic v;
      logic ok;
      base = code[6:0];
      v = 1'b0;
      ok = 1'b0;
      if (base == `IRH_CODE_ZERO)
      begin
         ok = 1'b1;
      end
      else if (base >= `IRH_CODE_PHYS_LO && base <= `IRH_CODE_PHYS_HI)
      begin
         k = base - `IRH_CODE_PHYS_LO;
         v = phys[k[3:0]];
         ok = 1'b1;
      end
      else if (base >= `IRH_CODE_HALL_U && base <= `IRH_CODE_HALL_W)
      begin
         k = base - `IRH_CODE_HALL_U;
         v = hall[k[1:0]];
         ok = 1'b1;
      end
      else if (base >= `IRH_CODE_ENC_A && base <= `IRH_CODE_ENC_I)
      begin
         k = base - `IRH_CODE_ENC_A;
         v = enc[k[1:0]];
         ok = 1'b1;
      end
      // Unlisted codes give zero, never the inverse
      return ok ? (v ^ code[`IRH_CODE_INV]) : 1'b0;
   endfunction

   function automatic irh_word_t irh_merge(
      input irh_word_t old,
      input irh_word_t wdat,
      input logic [3:0] sel);
      irh_word_t r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = wdat[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic irh_is_sel(input irh_adr_t adr);
      return adr >= `IRH_A_SEL_BASE && adr <= `IRH_A_SEL_LAST;
   endfunction

   function automatic logic [5:0] irh_sel_idx(input irh_adr_t adr);
      irh_adr_t d;
      d = adr - `IRH_A_SEL_BASE;
      return d[7:2];
   endfunction

endpackage

// ==== design/irh_top.sv ====
// Digital input routing with home switch capture, Wishbone classic slave.
// Assumes field inputs and positions are synchronous to clk_i.
`timescale 1ns/10ps
`include "irh_defs.svh"

// Operation
// RULE1 - 36 byte selectors drive status bits
// RULE2 - Code 00 gives zero, 80 gives one
// RULE3 - Codes 01-10 inputs, 81-90 inverted inputs
// RULE4 - Codes 41-43 hall, C1-C3 inverted hall
// RULE5 - Codes 44-46 encoder, C4-C6 inverted encoder
// RULE6 - Home edge captures position automatically
// RULE7 - Control 0 off, 1 rise, 2 fall, 3 both
// RULE8 - Count captures; cleared when control written 1-3
// RULE9 - Store user position at each capture
// RULE10 - Store raw encoder position at each capture
// RULE11 - Selectors act only while routing enabled
// RULE12 - Normally open high reads one, closed zero
// RULE13 - Unknown codes give zero; bits update each cycle
// RULE14 - Home synchronised, each edge counted once
module irh_top
   import irh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire irh_adr_t wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire irh_word_t wb_dat_i,
   output irh_word_t wb_dat_o,
   output logic wb_ack_o,
   input wire logic [`IRH_NUM_PHYS-1:0] phys_in_i,
   input wire logic [2:0] hall_i,
   input wire logic [2:0] enc_i,
   input wire irh_word_t actual_pos_i,
   input wire irh_word_t encoder_raw_i,
   output logic [`IRH_NUM_SEL-1:0] digital_input_status_word_o,
   output logic irq_o
);

   // Bus state
   logic req;
   logic wr;
   logic next_ack;
   irh_word_t next_dat;
   irh_word_t wmerge;

   // Software state
   logic route_en;
   logic next_route_en;
   logic [`IRH_NUM_PHYS-1:0] polarity;
   logic [`IRH_NUM_PHYS-1:0] next_polarity;
   irh_code_t sel_q [`IRH_NUM_SEL];
   irh_code_t next_sel [`IRH_NUM_SEL];
   irh_word_t cap_ctrl;
   irh_word_t next_cap_ctrl;
   logic [`IRH_IRQ_W-1:0] irq_stat;
   logic [`IRH_IRQ_W-1:0] next_irq_stat;
   logic [`IRH_IRQ_W-1:0] irq_mask;
   logic [`IRH_IRQ_W-1:0] next_irq_mask;

   // Datapath
   logic [`IRH_NUM_PHYS-1:0] phys_adj;
   logic [`IRH_NUM_SEL-1:0] routed;
   logic [`IRH_NUM_SEL-1:0] next_status;
   logic [1:0] cap_mode;
   logic cap_clear;
   logic capture;
   irh_word_t cap_count;
   irh_word_t cap_user;
   irh_word_t cap_raw;
   irh_word_t cur_word;
   logic [5:0] sidx;

   // Write strobes
   logic ctrl_we;
   logic cnt_we;
   logic user_we;
   logic raw_we;
   logic stat_we;
   logic sel_we;

   // Normally closed inputs flip before routing and the plain path
   assign phys_adj = phys_in_i ^ polarity; // [RULE12]

   genvar g;
   generate
      for (g = 0; g < `IRH_NUM_SEL; g++)
      begin : g_route
         irh_bit_select u_sel
         (
            .code_i(sel_q[g]), // [RULE1]
            .phys_i(phys_adj), // [RULE3]
            .hall_i(hall_i), // [RULE4]
            .enc_i(enc_i), // [RULE5]
            .bit_o(routed[g])
         );
      end
   endgenerate

   always_comb
   begin
      if (route_en)
      begin
         next_status = routed; // [RULE11]
      end
      else
      begin
         next_status = {{(`IRH_NUM_SEL-`IRH_NUM_PHYS){1'b0}}, phys_adj};
      end
   end

   // Ill-formed control values leave the capture unit idle
   assign cap_mode = (cap_ctrl > `IRH_CAP_MAX) ? `IRH_CAP_OFF
                                                : cap_ctrl[1:0]; // [RULE7]

   // Bus decode
   assign req = wb_cyc_i & wb_stb_i;
   // Writes land on the edge that also sees ack high
   assign wr = req & wb_we_i & wb_ack_o;
   assign sidx = irh_sel_idx(wb_adr_i);

   // One strobe per target, valid only on the edge that sees ack
   always_comb
   begin
      ctrl_we = wr && wb_adr_i == `IRH_A_CAP_CTRL;
      cnt_we = wr && wb_adr_i == `IRH_A_CAP_EVT;
      user_we = wr && wb_adr_i == `IRH_A_CAP_USER;
      raw_we = wr && wb_adr_i == `IRH_A_CAP_RAW;
      stat_we = wr && wb_adr_i == `IRH_A_IRQ_STAT && wb_sel_i[0];
      sel_we = wr && irh_is_sel(wb_adr_i) && wb_sel_i[0];
   end

   always_comb
   begin
      case (wb_adr_i)
         `IRH_A_ROUTE_EN: cur_word = {31'h0, route_en};
         `IRH_A_POLARITY: cur_word = {16'h0, polarity};
         `IRH_A_CAP_CTRL: cur_word = cap_ctrl;
         `IRH_A_CAP_EVT: cur_word = cap_count;
         `IRH_A_CAP_USER: cur_word = cap_user;
         `IRH_A_CAP_RAW: cur_word = cap_raw;
         `IRH_A_IRQ_MASK: cur_word = {30'h0, irq_mask};
         default: cur_word = `IRH_WORD_RESET;
      endcase
      wmerge = irh_merge(cur_word, wb_dat_i, wb_sel_i);
   end

   assign cap_clear = ctrl_we &&
                      wmerge != `IRH_WORD_RESET &&
                      wmerge <= `IRH_CAP_MAX; // [RULE8]

   irh_home_capture u_cap
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .home_i(digital_input_status_word_o[`IRH_HOME_BIT]), // [RULE6]
      .mode_i(cap_mode),
      .clear_i(cap_clear),
      .cnt_we_i(cnt_we),
      .user_we_i(user_we),
      .raw_we_i(raw_we),
      .wdata_i(wmerge),
      .user_pos_i(actual_pos_i), // [RULE9]
      .raw_pos_i(encoder_raw_i), // [RULE10]
      .count_o(cap_count),
      .user_o(cap_user),
      .raw_o(cap_raw),
      .capture_o(capture)
   );

   // Register writes
   always_comb
   begin
      next_route_en = route_en;
      next_polarity = polarity;
      next_cap_ctrl = cap_ctrl;
      next_irq_mask = irq_mask;
      for (int i = 0; i < `IRH_NUM_SEL; i++)
      begin
         next_sel[i] = sel_q[i];
      end
      if (wr)
      begin
         case (wb_adr_i)
            `IRH_A_ROUTE_EN: next_route_en = wmerge[0]; // [RULE11]
            `IRH_A_POLARITY: next_polarity = wmerge[15:0]; // [RULE12]
            `IRH_A_CAP_CTRL: next_cap_ctrl = wmerge; // [RULE7]
            `IRH_A_IRQ_MASK: next_irq_mask = wmerge[1:0];
            default: next_route_en = route_en;
         endcase
         if (sel_we)
         begin
            next_sel[sidx] = wb_dat_i[7:0]; // [RULE1]
         end
      end
   end

   // Sticky events; a new event beats the write-one clear
   always_comb
   begin
      next_irq_stat = irq_stat;
      if (stat_we)
      begin
         next_irq_stat = irq_stat & ~wb_dat_i[1:0];
      end
      if (capture)
      begin
         next_irq_stat[`IRH_IRQ_CAPTURE] = 1'b1;
      end
      if (next_status != digital_input_status_word_o)
      begin
         next_irq_stat[`IRH_IRQ_CHANGE] = 1'b1;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

   // Read data and acknowledge
   always_comb
   begin
      next_ack = req & ~wb_ack_o;
      next_dat = wb_dat_o;
      if (req && !wb_ack_o)
      begin
         case (wb_adr_i)
            `IRH_A_ROUTE_ENT: next_dat = {24'h0, `IRH_ROUTE_ENTRIES};
            `IRH_A_STATUS_LO:
               next_dat = digital_input_status_word_o[31:0];
            `IRH_A_STATUS_HI:
               next_dat = {28'h0, digital_input_status_word_o[35:32]};
            `IRH_A_CAP_ENT: next_dat = {24'h0, `IRH_CAP_ENTRIES};
            `IRH_A_IRQ_STAT: next_dat = {30'h0, irq_stat};
            default: next_dat = cur_word;
         endcase
         if (irh_is_sel(wb_adr_i))
         begin
            next_dat = {24'h0, sel_q[sidx]};
         end
      end
   end

   // Bus answer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `IRH_WORD_RESET;
      end
      else
      begin
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // Software registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         route_en <= 1'b0;
         polarity <= '0;
         cap_ctrl <= `IRH_WORD_RESET;
         irq_mask <= '0;
         for (int i = 0; i < `IRH_NUM_SEL; i++)
         begin
            sel_q[i] <= `IRH_SEL_RESET;
         end
      end
      else
      begin
         route_en <= next_route_en;
         polarity <= next_polarity;
         cap_ctrl <= next_cap_ctrl;
         irq_mask <= next_irq_mask;
         for (int i = 0; i < `IRH_NUM_SEL; i++)
         begin
            sel_q[i] <= next_sel[i];
         end
      end
   end

   // Sticky interrupt status
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_stat <= '0;
      end
      else
      begin
         irq_stat <= next_irq_stat;
      end
   end

   // Status word, refreshed every cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         digital_input_status_word_o <= '0;
      end
      else
      begin
         digital_input_status_word_o <= next_status; // [RULE13]
      end
   end

endmodule // irh_top

// ==== tb/irh_field_model.sv ====
// Field side model: physical, hall and encoder levels and positions.
// Assumes the bench calls its tasks; levels move just after a rising edge.
`timescale 1ns/10ps
`include "irh_defs.svh"

module irh_field_model
   import irh_pkg::*;
(
   input wire logic clk_i,
   output logic [`IRH_NUM_PHYS-1:0] phys_o,
   output logic [2:0] hall_o,
   output logic [2:0] enc_o,
   output irh_word_t pos_o,
   output irh_word_t raw_o
);
   // Raw counts per user unit, an arbitrary gearing
   localparam int RAW_SCALE = 4;

   initial
   begin
      phys_o = '0;
      hall_o = '0;
      enc_o = '0;
      pos_o = '0;
      raw_o = '0;
   end

   task automatic drive(input logic [15:0] p, input logic [2:0] h, e);
      @(posedge clk_i);
      phys_o <= p;
      hall_o <= h;
      enc_o <= e;
   endtask

   task automatic move(input irh_word_t p);
      @(posedge clk_i);
      pos_o <= p;
      raw_o <= p * RAW_SCALE;
   endtask
endmodule // irh_field_model

// ==== tb/irh_top_asserts.sv ====
// Port-level checks of the routing and home capture block.
// Assumes a bind from the bench; one clock, synchronous reset.
`timescale 1ns/10ps
`include "irh_defs.svh"

module irh_top_asserts
   import irh_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire irh_adr_t wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire irh_word_t wb_dat_i,
   input wire irh_word_t wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [`IRH_NUM_PHYS-1:0] phys_in_i,
   input wire logic [2:0] hall_i,
   input wire logic [2:0] enc_i,
   input wire irh_word_t actual_pos_i,
   input wire irh_word_t encoder_raw_i,
   input wire logic [`IRH_NUM_SEL-1:0] digital_input_status_word_o,
   input wire logic irq_o
);
   logic [21:0] in_q;
   logic in_chg;
   logic rd_req;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   assign in_chg = {phys_in_i, hall_i, enc_i} != in_q;
   assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   always_ff @(posedge clk_i)
   begin
      in_q <= {phys_in_i, hall_i, enc_i};
   end

   reset_clear_a: assert property ($past(rst_i) |->
      digital_input_status_word_o == '0 && !irq_o && !wb_ack_o)
      else $error("outputs not clear after reset");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acked next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   route_count_a: assert property (
      rd_req && wb_adr_i == `IRH_A_ROUTE_ENT |=> wb_dat_o == 32'h24)
      else $error("entry count read wrong");
   status_lo_a: assert property (
      rd_req && wb_adr_i == `IRH_A_STATUS_LO
      |=> wb_dat_o == $past(digital_input_status_word_o[31:0]))
      else $error("status low read differs from port");
   status_hi_a: assert property (
      rd_req && wb_adr_i == `IRH_A_STATUS_HI
      |=> wb_dat_o == {28'h0, $past(digital_input_status_word_o[35:32])})
      else $error("status high read differs from port");
   unmapped_a: assert property (rd_req && wb_adr_i == 8'h30
      |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   status_cause_a: assert property (
      !$stable(digital_input_status_word_o) |-> $past(in_chg)
      || $past(in_chg, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2)
      || $past(rst_i) || $past(rst_i, 2))
      else $error("status changed without cause");
endmodule // irh_top_asserts

// ==== tb/tb.sv ====
// Self-checking bench: register tests over Wishbone, routing, capture.
// Assumes the field model and the checker are compiled before it.
`timescale 1ns/10ps
`include "irh_defs.svh"

module tb
   import irh_pkg::*;
();
   logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq;
   irh_adr_t wb_adr;
   logic [3:0] wb_sel;
   irh_word_t wb_wdat, wb_rdat, pos, raw, cnt, up;
   logic [15:0] phys;
   logic [2:0] hall, enc;
   logic [35:0] status;
   int miscompares = 0;
   int n_checks = 0;

   irh_field_model fm (.clk_i(clk), .phys_o(phys), .hall_o(hall),
      .enc_o(enc), .pos_o(pos), .raw_o(raw));

   irh_top dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .phys_in_i(phys), .hall_i(hall), .enc_i(enc),
      .actual_pos_i(pos), .encoder_raw_i(raw),
      .digital_input_status_word_o(status), .irq_o(irq));

   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic xfer(input irh_adr_t a, input logic we, input irh_word_t d,
      output irh_word_t q);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdat <= d;
      wb_sel <= 4'hf;
      @(posedge clk);
      while (wb_ack !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      check(n < 20, 1'b1);
      if (n >= 20)
      begin
         results();
      end
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input irh_adr_t a, input irh_word_t d);
      irh_word_t q;
      xfer(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input irh_adr_t a, input irh_word_t exp);
      irh_word_t q;
      xfer(a, 1'b0, 32'h0, q);
      check(q, exp);
   endtask

   task automatic settle();
      repeat (4) @(posedge clk);
   endtask

   // Expected routed bit, worked out independently of the design
   function automatic logic ref_bit(input logic [7:0] c);
      logic [6:0] b;
      logic v;
      b = c[6:0];
      if (b >= 7'h01 && b <= 7'h10)
         v = phys[b - 7'h01];
      else if (b >= 7'h41 && b <= 7'h43)
         v = hall[b - 7'h41];
      else if (b >= 7'h44 && b <= 7'h46)
         v = enc[b - 7'h44];
      else if (b == 7'h00)
         v = 1'b0;
      else
         return 1'b0;
      return v ^ c[7];
   endfunction

   task automatic results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end

   initial
   begin
      rst = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = '0;
      wb_sel = '0;
      wb_wdat = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(`IRH_A_ROUTE_ENT, 32'h24);
      rd_chk(`IRH_A_CAP_ENT, 32'h04);
      rd_chk(`IRH_A_SEL_LAST, 32'h00);
      rd_chk(`IRH_A_CAP_CTRL, 32'h00);
      rd_chk(8'h30, 32'h00);
      wr(`IRH_A_ROUTE_ENT, 32'hff);
      rd_chk(`IRH_A_ROUTE_ENT, 32'h24);
      $display("reset and map test done");
      fm.drive(16'ha5c3, 3'b101, 3'b011);
      wr(`IRH_A_POLARITY, 32'hffff);
      settle();
      check(status, {20'h0, ~phys});
      wr(`IRH_A_POLARITY, 32'h0);
      settle();
      check(status, {20'h0, phys});
      rd_chk(`IRH_A_STATUS_LO, {16'h0, phys});
      rd_chk(`IRH_A_STATUS_HI, 32'h0);
      $display("normal path test done");
      wr(`IRH_A_ROUTE_EN, 32'h1);
      for (int c = 0; c < 256; c++)
      begin
         wr(`IRH_A_SEL_BASE, c);
         wr(`IRH_A_SEL_LAST, c);
         rd_chk(`IRH_A_SEL_BASE, c);
         settle();
         check({status[35], status[0]}, {2{ref_bit(c[7:0])}});
         rd_chk(`IRH_A_STATUS_HI, {28'h0, ref_bit(c[7:0]), 3'h0});
      end
      $display("source code test done");
      wr(`IRH_A_SEL_BASE + 8'h08, 32'h01);
      fm.drive(16'h0000, hall, enc);
      cnt = 0;
      up = 0;
      for (int m = 0; m < 4; m++)
      begin
         fm.move(32'h100 + m);
         wr(`IRH_A_CAP_CTRL, m);
         if (m != 0)
            cnt = 0;
         fm.drive(16'h0001, hall, enc);
         repeat (6) @(posedge clk);
         fm.drive(16'h0000, hall, enc);
         repeat (6) @(posedge clk);
         cnt = cnt + m[0] + m[1];
         if (m != 0)
            up = 32'h100 + m;
         rd_chk(`IRH_A_CAP_EVT, cnt);
         rd_chk(`IRH_A_CAP_USER, up);
         rd_chk(`IRH_A_CAP_RAW, up * fm.RAW_SCALE);
      end
      wr(`IRH_A_CAP_EVT, 32'h5);
      wr(`IRH_A_CAP_CTRL, 32'h4);
      rd_chk(`IRH_A_CAP_CTRL, 32'h4);
      rd_chk(`IRH_A_CAP_EVT, 32'h5);
      wr(`IRH_A_CAP_CTRL, 32'h3);
      rd_chk(`IRH_A_CAP_EVT, 32'h0);
      wr(`IRH_A_CAP_USER, 32'h1234);
      rd_chk(`IRH_A_CAP_USER, 32'h1234);
      $display("home capture test done");
      rd_chk(`IRH_A_IRQ_STAT, 32'h3);
      check(irq, 1'b0);
      for (int b = 0; b < 2; b++)
      begin
         wr(`IRH_A_IRQ_MASK, 32'h1 << b);
         settle();
         check(irq, 1'b1);
         wr(`IRH_A_IRQ_STAT, 32'h1 << b);
         settle();
         check(irq, 1'b0);
      end
      rd_chk(`IRH_A_IRQ_STAT, 32'h0);
      $display("interrupt test done");
      results();
   end
endmodule // tb

bind irh_top irh_top_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phys_in_i(phys_in_i),
   .hall_i(hall_i), .enc_i(enc_i), .actual_pos_i(actual_pos_i),
   .encoder_raw_i(encoder_raw_i),
   .digital_input_status_word_o(digital_input_status_word_o),
   .irq_o(irq_o));
